// [logic/irq_gate_pkg.sv]
`default_nettype none
package irq_gate_pkg;
  // bus geometry: byte address is four times the register index
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned SRC_N = 11;

  // register indices of the event flags
  localparam logic [15:0] PTIMER_FLAG_IDX = 16'hfff2;
  localparam logic [15:0] SERIAL_FLAG_IDX = 16'hfff3;
  localparam logic [15:0] KEYGRP0_FLAG_IDX = 16'hfff4;
  localparam logic [15:0] KEYGRP12_FLAG_IDX = 16'hfff5;
  localparam logic [15:0] CLKTMR_FLAG_IDX = 16'hfff6;
  localparam logic [15:0] ADC_FLAG_IDX = 16'hfff7;
  // register indices of the enables
  localparam logic [15:0] PTIMER_EN_IDX = 16'hffe2;
  localparam logic [15:0] ADC_EN_IDX = 16'hffe7;
  // read-only status of the gate, stack pointers and halt
  localparam logic [15:0] IRQ_STATUS_IDX = 16'hffe8;

  // source positions inside the packed flag and enable vectors
  localparam int unsigned SRC_PT0 = 0;
  localparam int unsigned SRC_PT1 = 1;
  localparam int unsigned SRC_SER = 2;
  localparam int unsigned SRC_K0 = 3;
  localparam int unsigned SRC_K1 = 4;
  localparam int unsigned SRC_K2 = 5;
  localparam int unsigned SRC_T16 = 6;
  localparam int unsigned SRC_T8 = 7;
  localparam int unsigned SRC_T2 = 8;
  localparam int unsigned SRC_T1 = 9;
  localparam int unsigned SRC_ADC = 10;

  // reset values
  localparam logic [SRC_N-1:0] FLAGS_RST = 11'h000;
  localparam logic [SRC_N-1:0] ENABLES_RST = 11'h000;

  // vector: fixed upper part and low nibble per source
  localparam logic [11:0] VEC_BASE = 12'h010;
  localparam logic [3:0] VEC_WDT = 4'h0;
  localparam logic [3:0] VEC_PT = 4'h4;
  localparam logic [3:0] VEC_SER = 4'h6;
  localparam logic [3:0] VEC_K0 = 4'h8;
  localparam logic [3:0] VEC_K12 = 4'ha;
  localparam logic [3:0] VEC_CT = 4'hc;
  localparam logic [3:0] VEC_ADC = 4'he;

  // status register bit positions
  localparam int unsigned ST_GATE = 0;
  localparam int unsigned ST_SP_OK = 1;
  localparam int unsigned ST_HALT = 2;
  localparam int unsigned ST_NMI = 3;
  localparam int unsigned ST_REQ = 4;
  localparam int unsigned ST_VEC = 8;
endpackage : irq_gate_pkg
`default_nettype wire

// [logic/event_flag_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module event_flag_bank
  import irq_gate_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // per-source set pulses and write-one clears
  input wire logic [SRC_N-1:0] set_i,
  input wire logic [SRC_N-1:0] clr_i,
  // flag state
  output logic [SRC_N-1:0] flags_o
);

  // one sticky flag per source; a set beats a clear in the same cycle
  for (genvar i = 0; i < SRC_N; i++) begin : g_flag
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        flags_o[i] <= FLAGS_RST[i];
      end else if (set_i[i]) begin
        flags_o[i] <= 1'b1;
      end else if (clr_i[i]) begin
        flags_o[i] <= 1'b0;
      end
    end
  end

endmodule : event_flag_bank
`default_nettype wire

// [logic/irq_prio_select.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_prio_select
  import irq_gate_pkg::*;
(
  // requests
  input wire logic nmi_i,
  input wire logic [SRC_N-1:0] flags_i,
  input wire logic [SRC_N-1:0] enables_i,
  // selection
  output logic maskable_o,
  output logic [3:0] code_o
);

  logic [SRC_N-1:0] live;
  logic grp_pt;
  logic grp_ser;
  logic grp_k0;
  logic grp_k12;
  logic grp_ct;
  logic grp_adc;

  assign live = flags_i & enables_i;
  assign grp_pt = live[SRC_PT0] | live[SRC_PT1];
  assign grp_ser = live[SRC_SER];
  assign grp_k0 = live[SRC_K0];
  assign grp_k12 = live[SRC_K1] | live[SRC_K2];
  assign grp_ct = |live[SRC_T1:SRC_T16];
  assign grp_adc = live[SRC_ADC];
  assign maskable_o = |live;

  always_comb begin
    code_o = VEC_ADC;
    if (nmi_i) begin
      code_o = VEC_WDT;
    end else if (grp_pt) begin
      code_o = VEC_PT;
    end else if (grp_ser) begin
      code_o = VEC_SER;
    end else if (grp_k0) begin
      code_o = VEC_K0;
    end else if (grp_k12) begin
      code_o = VEC_K12;
    end else if (grp_ct) begin
      code_o = VEC_CT;
    end else if (grp_adc) begin
      code_o = VEC_ADC;
    end
  end

endmodule : irq_prio_select
`default_nettype wire

// [logic/interrupt_gate_and_halt_wake.sv]
// Notes on behaviour
// - maskable request needs pending flag, enable bit and open gate.
// - accepting an interrupt closes the global gate automatically.
// - watchdog request ignores gate, has no enable and no flag.
// - writing one clears a pending flag, writing zero keeps it.
// - initial reset clears every pending flag.
// - after reset all requests blocked until both stack pointers written.
// - writing one stack pointer blocks all until the other is written.
// - halt stops the core while timers keep raising events.
// - any hardware request, watchdog included, releases the halt.
// - timer 0 and 1 reaching zero set their pending flags.
// - finished 8-bit serial transfer sets the serial flag.
// - qualified group-0 key edge sets the group-0 flag.
// - group-1 and group-2 key edges set their own flags.
// - falling 1, 2, 8, 16 Hz edges set clock-timer flags.
// - flag left set raises the interrupt again after reopening.
// - each source has a read/write enable, cleared by reset.
// - acceptance closes gate; core then stacks and jumps to vector.
// - vectors 0100H to 010EH by source in fixed priority order.
`timescale 1ns/1ps
`default_nettype none
module interrupt_gate_and_halt_wake
  import irq_gate_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // peripheral event pulses
  input wire logic ptimer0_zero_i,
  input wire logic ptimer1_zero_i,
  input wire logic serial_done_i,
  input wire logic keygrp0_edge_i,
  input wire logic keygrp1_edge_i,
  input wire logic keygrp2_edge_i,
  input wire logic adc_done_i,
  input wire logic wdt_req_i,
  // clock-timer levels
  input wire logic clk16hz_i,
  input wire logic clk8hz_i,
  input wire logic clk2hz_i,
  input wire logic clk1hz_i,
  // core handshake pulses
  input wire logic gate_open_i,
  input wire logic gate_close_i,
  input wire logic return_from_handler_i,
  input wire logic stack_ptr_one_wr_i,
  input wire logic stack_ptr_two_wr_i,
  input wire logic halt_i,
  input wire logic irq_ack_i,
  // to the core
  output logic irq_req_o,
  output logic nmi_req_o,
  output logic [15:0] vector_o,
  output logic halted_o,
  output logic gate_open_state_o
);

  // decoded register index and word alignment
  logic [15:0] idx;
  logic aligned;
  logic flag_hit;
  logic en_hit;
  logic stat_hit;
  logic mapped;
  logic setup_ph;
  logic wr_done;
  logic lane0;

  // flag and enable state
  logic [SRC_N-1:0] flags;
  logic [SRC_N-1:0] set_vec;
  logic [SRC_N-1:0] clr_vec;
  logic [SRC_N-1:0] enables_q;

  // clock-timer edge history
  logic [3:0] ct_prev_q;
  logic [3:0] ct_now;
  logic [3:0] ct_fall;

  // gate, stack pointer pairing, halt, watchdog
  logic gate_q;
  logic sp_one_seen_q;
  logic sp_two_seen_q;
  logic sp_ok_q;
  logic nmi_pend_q;
  logic halted_q;

  // selection
  logic maskable;
  logic [3:0] code;
  logic req_d;
  logic nmi_d;
  logic wake;
  logic [31:0] status_word;
  logic [31:0] rdata_d;

  // packs the sources of one register index into its four data bits
  function automatic logic [3:0] reg_nibble(
    input logic [2:0] sel,
    input logic [SRC_N-1:0] v
  );
    logic [3:0] n;
    n = 4'h0;
    unique case (sel)
      3'd2: n = {2'b00, v[SRC_PT1], v[SRC_PT0]};
      3'd3: n = {3'b000, v[SRC_SER]};
      3'd4: n = {3'b000, v[SRC_K0]};
      3'd5: n = {2'b00, v[SRC_K2], v[SRC_K1]};
      3'd6: n = {v[SRC_T1], v[SRC_T2], v[SRC_T8], v[SRC_T16]};
      3'd7: n = {3'b000, v[SRC_ADC]};
      default: n = 4'h0;
    endcase
    return n;
  endfunction : reg_nibble

  // spreads four data bits of one register index over the sources
  function automatic logic [SRC_N-1:0] reg_spread(
    input logic [2:0] sel,
    input logic [3:0] d
  );
    logic [SRC_N-1:0] m;
    m = '0;
    unique case (sel)
      3'd2: begin
        m[SRC_PT0] = d[0];
        m[SRC_PT1] = d[1];
      end
      3'd3: m[SRC_SER] = d[0];
      3'd4: m[SRC_K0] = d[0];
      3'd5: begin
        m[SRC_K1] = d[0];
        m[SRC_K2] = d[1];
      end
      3'd6: begin
        m[SRC_T16] = d[0];
        m[SRC_T8] = d[1];
        m[SRC_T2] = d[2];
        m[SRC_T1] = d[3];
      end
      3'd7: m[SRC_ADC] = d[0];
      default: m = '0;
    endcase
    return m;
  endfunction : reg_spread

  // address decode over the flag page, enable page and status word
  assign idx = paddr_i[ADDR_W-1:2];
  assign aligned = (paddr_i[1:0] == 2'b00);
  assign flag_hit = aligned && (idx >= PTIMER_FLAG_IDX)
                    && (idx <= ADC_FLAG_IDX);
  assign en_hit = aligned && (idx >= PTIMER_EN_IDX)
                  && (idx <= ADC_EN_IDX);
  assign stat_hit = aligned && (idx == IRQ_STATUS_IDX);
  assign mapped = flag_hit || en_hit || stat_hit;
  assign setup_ph = psel_i && !penable_i;
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign lane0 = pstrb_i[0];

  assign ct_now = {clk1hz_i, clk2hz_i, clk8hz_i, clk16hz_i};
  assign ct_fall = ct_prev_q & ~ct_now;
  always_comb begin
    set_vec = '0;
    set_vec[SRC_PT0] = ptimer0_zero_i;
    set_vec[SRC_PT1] = ptimer1_zero_i;
    set_vec[SRC_SER] = serial_done_i;
    set_vec[SRC_K0] = keygrp0_edge_i;
    set_vec[SRC_K1] = keygrp1_edge_i;
    set_vec[SRC_K2] = keygrp2_edge_i;
    set_vec[SRC_T16] = ct_fall[0];
    set_vec[SRC_T8] = ct_fall[1];
    set_vec[SRC_T2] = ct_fall[2];
    set_vec[SRC_T1] = ct_fall[3];
    set_vec[SRC_ADC] = adc_done_i;
  end

  always_comb begin
    clr_vec = '0;
    if (wr_done && flag_hit && lane0) begin
      clr_vec = reg_spread(idx[2:0], pwdata_i[3:0]);
    end
  end

  // clock-timer level history
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ct_prev_q <= 4'h0;
    end else begin
      ct_prev_q <= ct_now;
    end
  end

  // pending flags, set wins over clear
  event_flag_bank u_flags (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .set_i(set_vec),
    .clr_i(clr_vec),
    .flags_o(flags)
  );

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      enables_q <= ENABLES_RST;
    end else if (wr_done && en_hit && lane0) begin
      enables_q <= (enables_q & ~reg_spread(idx[2:0], 4'hf))
                   | reg_spread(idx[2:0], pwdata_i[3:0]);
    end
  end

  // global gate; acceptance has priority over software opening
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      gate_q <= 1'b0;
    end else if (irq_ack_i) begin
      gate_q <= 1'b0;
    end else if (gate_close_i) begin
      gate_q <= 1'b0;
    end else if (gate_open_i || return_from_handler_i) begin
      gate_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sp_one_seen_q <= 1'b0;
      sp_two_seen_q <= 1'b0;
      sp_ok_q <= 1'b0;
    end else if (stack_ptr_one_wr_i || stack_ptr_two_wr_i) begin
      // one write blocks until the other
      if ((stack_ptr_one_wr_i || sp_one_seen_q)
          && (stack_ptr_two_wr_i || sp_two_seen_q)) begin
        sp_ok_q <= 1'b1;
        sp_one_seen_q <= 1'b0;
        sp_two_seen_q <= 1'b0;
      end else begin
        sp_ok_q <= 1'b0;
        sp_one_seen_q <= sp_one_seen_q | stack_ptr_one_wr_i;
        sp_two_seen_q <= sp_two_seen_q | stack_ptr_two_wr_i;
      end
    end
  end

  // watchdog request held until the core takes it
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      nmi_pend_q <= 1'b0;
    end else if (wdt_req_i) begin
      nmi_pend_q <= 1'b1;
    end else if (irq_ack_i && nmi_req_o) begin
      nmi_pend_q <= 1'b0;
    end
  end

  irq_prio_select u_prio (
    .nmi_i(nmi_pend_q),
    .flags_i(flags),
    .enables_i(enables_q),
    .maskable_o(maskable),
    .code_o(code)
  );

  // a flag still set asks again
  assign nmi_d = sp_ok_q && nmi_pend_q;
  assign req_d = nmi_d || (sp_ok_q && gate_q && maskable);
  assign wake = nmi_pend_q || maskable;

  // halt state, timers outside keep running
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      halted_q <= 1'b0;
    end else if (wake) begin
      halted_q <= 1'b0;
    end else if (halt_i) begin
      halted_q <= 1'b1;
    end
  end

  // registered requests and vector to the core
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_req_o <= 1'b0;
      nmi_req_o <= 1'b0;
      vector_o <= {VEC_BASE, VEC_WDT};
    end else begin
      irq_req_o <= req_d;
      nmi_req_o <= nmi_d;
      vector_o <= {VEC_BASE, code};
    end
  end

  // status outputs
  assign halted_o = halted_q;
  assign gate_open_state_o = gate_q;

  // read mux
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_GATE] = gate_q;
    status_word[ST_SP_OK] = sp_ok_q;
    status_word[ST_HALT] = halted_q;
    status_word[ST_NMI] = nmi_pend_q;
    status_word[ST_REQ] = irq_req_o;
    status_word[ST_VEC +: 4] = vector_o[3:0];
    rdata_d = 32'h0000_0000;
    if (flag_hit) begin
      rdata_d[3:0] = reg_nibble(idx[2:0], flags);
    end else if (en_hit) begin
      rdata_d[3:0] = reg_nibble(idx[2:0], enables_q);
    end else if (stat_hit) begin
      rdata_d = status_word;
    end
  end

  // apb answer: one wait-free access phase after setup
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready_o <= 1'b1;
      pslverr_o <= !mapped || (pwrite_i && stat_hit);
      prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_d;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

endmodule : interrupt_gate_and_halt_wake
`default_nettype wire

// [dv/irq_gate_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_gate_checker
  import irq_gate_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // bus and core strobes
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic gate_open_i,
  input wire logic gate_close_i,
  input wire logic stack_ptr_one_wr_i,
  input wire logic stack_ptr_two_wr_i,
  input wire logic halt_i,
  input wire logic irq_ack_i,
  input wire logic wdt_req_i,
  // toward the core
  input wire logic irq_req_o,
  input wire logic nmi_req_o,
  input wire logic [15:0] vector_o,
  input wire logic halted_o,
  input wire logic gate_open_state_o
);
  logic seen1_q;
  logic seen2_q;

  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // stack pointer writes seen since reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      seen1_q <= 1'b0;
      seen2_q <= 1'b0;
    end else begin
      seen1_q <= seen1_q | stack_ptr_one_wr_i;
      seen2_q <= seen2_q | stack_ptr_two_wr_i;
    end
  end

  AST_ACK_CLOSES: assert property (
    irq_ack_i |=> !gate_open_state_o) else $error("gate open after ack");
  AST_GATE_OPENS: assert property (
    gate_open_i && !gate_close_i && !irq_ack_i |=> gate_open_state_o)
    else $error("gate did not open");
  AST_REQ_NEEDS_GATE: assert property (
    irq_req_o && !nmi_req_o |-> $past(gate_open_state_o))
    else $error("maskable request with gate closed");
  AST_NMI_IS_REQ: assert property (
    nmi_req_o |-> irq_req_o) else $error("watchdog request not raised");
  AST_SP_BOTH: assert property (
    irq_req_o |-> seen1_q && seen2_q) else $error("request before sp pair");
  AST_NMI_VECTOR: assert property (
    nmi_req_o |-> vector_o == 16'h0100) else $error("bad watchdog vector");
  AST_VEC_FORM: assert property (
    irq_req_o |-> vector_o[15:4] == 12'h010 && !vector_o[0]
      && vector_o[3:0] != 4'h2) else $error("bad vector form");
  AST_HALT_ENTER: assert property (
    $rose(halted_o) |-> $past(halt_i)) else $error("halt without request");
  AST_NMI_WAKE: assert property (
    halted_o && wdt_req_i |=> ##1 !halted_o)
    else $error("watchdog did not wake");
  AST_APB_READY: assert property (
    psel_i && !penable_i |=> pready_o) else $error("no ready in access");
endmodule : irq_gate_checker

bind interrupt_gate_and_halt_wake irq_gate_checker u_irq_gate_checker (
  .clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pready_o, .gate_open_i,
  .gate_close_i, .stack_ptr_one_wr_i, .stack_ptr_two_wr_i, .halt_i,
  .irq_ack_i, .wdt_req_i, .irq_req_o, .nmi_req_o, .vector_o, .halted_o,
  .gate_open_state_o
);
`default_nettype wire

// [dv/irq_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // request and bench control
  input wire logic irq_req_i,
  input wire logic ack_en_i,
  // acceptance pulse
  output logic irq_ack_o
);
  logic [1:0] hold_q;

  // accept, then hold off
  // hold-off lets the gate drop the request before a second accept
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_ack_o <= 1'b0;
      hold_q <= 2'h0;
    end else begin
      irq_ack_o <= irq_req_i && ack_en_i && hold_q == 2'h0 && !irq_ack_o;
      if (irq_ack_o) begin
        hold_q <= 2'h3;
      end else if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end
    end
  end
endmodule : irq_core_model
`default_nettype wire

// [dv/tb_interrupt_gate_and_halt_wake.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_gate_and_halt_wake;
  import irq_gate_pkg::*;
  localparam int WD = 11, GO = 12, GC = 13, RH = 14;
  localparam int S1 = 15, S2 = 16, HL = 17;
  logic clk_sys_i, sys_rst_i, psel_i, penable_i, pwrite_i, ack_en;
  logic pready_o, pslverr_o, irq_ack_i, irq_req_o, nmi_req_o, err;
  logic halted_o, gate_open_state_o;
  logic [ADDR_W-1:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, b;
  logic [3:0] pstrb_i;
  logic [15:0] vector_o, f;
  logic [17:0] p;
  int n_mismatch, total_checks;
  int ri[11] = '{0, 0, 1, 2, 3, 3, 4, 4, 4, 4, 5};
  int rb[11] = '{0, 1, 0, 0, 0, 1, 0, 1, 2, 3, 0};
  int sv[6] = '{0, 2, 3, 4, 6, 10};
  logic [3:0] vc[6] = '{VEC_PT, VEC_SER, VEC_K0, VEC_K12, VEC_CT, VEC_ADC};
  logic [3:0] mk[6] = '{4'h3, 4'h1, 4'h1, 4'h3, 4'hf, 4'h1};

  interrupt_gate_and_halt_wake u_interrupt_gate_and_halt_wake (
    .clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .ptimer0_zero_i(p[0]), .ptimer1_zero_i(p[1]), .serial_done_i(p[2]),
    .keygrp0_edge_i(p[3]), .keygrp1_edge_i(p[4]), .keygrp2_edge_i(p[5]),
    .adc_done_i(p[10]), .wdt_req_i(p[WD]), .clk16hz_i(p[6]),
    .clk8hz_i(p[7]), .clk2hz_i(p[8]), .clk1hz_i(p[9]),
    .gate_open_i(p[GO]), .gate_close_i(p[GC]),
    .return_from_handler_i(p[RH]), .stack_ptr_one_wr_i(p[S1]),
    .stack_ptr_two_wr_i(p[S2]), .halt_i(p[HL]), .irq_ack_i, .irq_req_o,
    .nmi_req_o, .vector_o, .halted_o, .gate_open_state_o
  );

  irq_core_model u_irq_core_model (
    .clk_sys_i, .sys_rst_i, .irq_req_i(irq_req_o), .ack_en_i(ack_en),
    .irq_ack_o(irq_ack_i)
  );

  task automatic results;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [15:0] ix,
                     input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {ix, 2'b00};
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) cmp(0, 1);
    // idle cycle so the next setup never reassigns psel in this step
    @(posedge clk_sys_i);
  endtask : apb

  task automatic rdc(input logic [15:0] ix, input logic [31:0] exp);
    apb(1'b0, ix, 32'h0);
    cmp(rd, exp);
  endtask : rdc

  task automatic pulse(input int k);
    p[k] <= 1'b1;
    @(posedge clk_sys_i);
    p[k] <= 1'b0;
    @(posedge clk_sys_i);
  endtask : pulse

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wt

  // wait for the core to accept, bounded
  task automatic wack;
    int n;
    n = 0;
    while (irq_ack_i !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    cmp(n < 40, 1);
  endtask : wack

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    wt(4000);
    n_mismatch++;
    results();
  end

  initial begin
    {psel_i, penable_i, pwrite_i, ack_en} = 4'h0;
    paddr_i = '0;
    pwdata_i = 32'h0;
    pstrb_i = 4'hf;
    p = '0;
    sys_rst_i = 1'b1;
    wt(12);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rdc(PTIMER_FLAG_IDX + 16'(i), 0);
      rdc(PTIMER_EN_IDX + 16'(i), 0);
      apb(1'b1, PTIMER_EN_IDX + 16'(i), 32'hffffffff);
      rdc(PTIMER_EN_IDX + 16'(i), 32'(mk[i]));
    end
    // idle vector shows the code of the lowest-priority source, ADC
    rdc(IRQ_STATUS_IDX, 32'(VEC_ADC) << ST_VEC);
    apb(1'b0, 16'hfff8, 0);
    cmp(err, 1);
    // each event sets its own flag and no other flag in the same register
    for (int i = 0; i < 11; i++) begin
      f = PTIMER_FLAG_IDX + 16'(ri[i]);
      b = 32'h1 << rb[i];
      pulse(i);
      wt(1);
      rdc(f, b);
      apb(1'b1, f, 32'h0);
      rdc(f, b);
      apb(1'b1, f, b);
      rdc(f, 0);
    end
    // blocked until both stack pointers written
    pulse(10);
    pulse(WD);
    pulse(GO);
    wt(3);
    cmp(irq_req_o, 0);
    pulse(GC);
    pulse(S1);
    pulse(S2);
    wt(2);
    cmp(nmi_req_o, 1);
    cmp(vector_o, 16'h0100);
    ack_en <= 1'b1;
    wack();
    wt(4);
    cmp(irq_req_o, 0);
    apb(1'b1, ADC_FLAG_IDX, 1);
    for (int k = 0; k < 6; k++) begin
      pulse(sv[k]);
      pulse(GO);
      wack();
      cmp(vector_o, {VEC_BASE, vc[k]});
      wt(2);
      cmp(gate_open_state_o, 0);
      apb(1'b1, PTIMER_FLAG_IDX + 16'(ri[sv[k]]), 32'h1 << rb[sv[k]]);
    end
    pulse(10);
    pulse(0);
    pulse(GO);
    wack();
    cmp(vector_o, 16'h0104);
    rdc(ADC_FLAG_IDX, 1);
    apb(1'b1, PTIMER_FLAG_IDX, 1);
    pulse(RH);
    wack();
    cmp(vector_o, 16'h010e);
    apb(1'b1, ADC_FLAG_IDX, 1);
    apb(1'b1, PTIMER_EN_IDX, 2);
    pulse(0);
    pulse(GO);
    wt(4);
    cmp(irq_req_o, 0);
    apb(1'b1, PTIMER_FLAG_IDX, 1);
    pulse(GC);
    ack_en <= 1'b0;
    pulse(HL);
    wt(1);
    cmp(halted_o, 1);
    pulse(1);
    wt(2);
    cmp(halted_o, 0);
    apb(1'b1, PTIMER_FLAG_IDX, 2);
    // write with lane 0 off must leave the enables alone
    pstrb_i <= 4'h0;
    apb(1'b1, PTIMER_EN_IDX, 32'h0);
    pstrb_i <= 4'hf;
    rdc(PTIMER_EN_IDX, 32'h2);
    pulse(HL);
    wt(1);
    pulse(WD);
    wt(2);
    cmp(halted_o, 0);
    pulse(S1);
    wt(2);
    cmp(irq_req_o, 0);
    pulse(S2);
    wt(2);
    cmp(nmi_req_o, 1);
    ack_en <= 1'b1;
    wack();
    results();
  end
endmodule : tb_interrupt_gate_and_halt_wake
`default_nettype wire
